// ---- bench/iic_data_ack_sva.sv ----
// Purpose: port-level assertions for the two-wire data/ack unit
// Assumes: bound to the unit top, one clock domain
// Notes:   scl check is only a floor, the divisor picks the real length
`timescale 1ns/1ps
module iic_data_ack_sva
(
   input wire logic        i_ref_clk,
   input wire logic        i_rst,
   input wire logic        i_axi_awvalid,
   input wire logic        o_axi_awready,
   input wire logic        i_axi_wvalid,
   input wire logic        o_axi_wready,
   input wire logic        o_axi_bvalid,
   input wire logic        i_axi_bready,
   input wire logic [1:0]  o_axi_bresp,
   input wire logic        i_axi_arvalid,
   input wire logic        o_axi_arready,
   input wire logic        o_axi_rvalid,
   input wire logic        i_axi_rready,
   input wire logic [31:0] o_axi_rdata,
   input wire logic        i_scl_in,
   input wire logic        o_scl_out,
   input wire logic        o_scl_oe_n,
   input wire logic        o_sda_out,
   input wire logic        o_sda_oe_n
);
   default clocking dc @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   AST_BRESP_HOLD: assert property (
      o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp))
      else $error("write response dropped early");
   AST_RDATA_HOLD: assert property (
      o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata))
      else $error("read data dropped early");
   AST_RDATA_BYTE: assert property (o_axi_rvalid |-> o_axi_rdata[31:8] == 24'h0)
      else $error("read data wider than a byte");
   AST_PIN_LOW: assert property (!o_scl_out && !o_sda_out)
      else $error("open-drain output not low");
   AST_WR_RESP: assert property (
      i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready |-> ##2 o_axi_bvalid)
      else $error("write response late");
   AST_RD_RESP: assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid)
      else $error("read response late");
   AST_AR_DROP: assert property (i_axi_arvalid && o_axi_arready |=> !o_axi_arready)
      else $error("read address taken twice");
   AST_SCL_HIGH: assert property ($rose(o_scl_oe_n) |-> o_scl_oe_n [*8])
      else $error("scl high phase too short");
   AST_SDA_MOVE: assert property (
      $changed(o_sda_oe_n) |-> !o_scl_oe_n || !i_scl_in)
      else $error("sda moved while scl high");
   COV_WR: cover property (o_axi_bvalid && i_axi_bready);
   COV_RD: cover property (o_axi_rvalid && i_axi_rready);
   COV_FRAME: cover property ($fell(o_scl_oe_n));
endmodule // iic_data_ack_sva

// ---- bench/iic_peer_model.sv ----
// Purpose: far-side receiver on the two-wire bus
// Assumes: never pulls scl; released sda floats high by pull-up
// Notes:   acks after eight data bits only when told to
`timescale 1ns/1ps
module iic_peer_model
(
   input wire logic  i_rst,
   input wire logic  i_scl,
   input wire logic  i_sda,
   input wire logic  i_ack_en,
   output logic       o_sda_oe_n,
   output logic [7:0] o_byte
);
   int rises = 0;
   initial o_sda_oe_n = 1'b1;
   always @(posedge i_scl)
   begin
      rises = i_rst ? 0 : rises + 1;
      if (rises <= 8) o_byte <= {o_byte[6:0], i_sda};
   end
   always @(negedge i_scl)
   begin
      if (rises == 8) o_sda_oe_n <= !i_ack_en;
      if (rises >= 9)
      begin
         o_sda_oe_n <= 1'b1;
         rises = 0;
      end
   end
endmodule // iic_peer_model

// ---- bench/tb_iic_data_ack_unit.sv ----
// Purpose: register-level tests of the two-wire data/ack unit
// Assumes: peer model receives, scl only pulled by the unit
// Notes:   the receive frame samples a released line, so it reads all ones
`timescale 1ns/1ps
module tb_iic_data_ack_unit;
   import iic_pkg::*;
   logic i_ref_clk = 1'b0, i_rst = 1'b1, ack_en = 1'b0;
   logic i_axi_awvalid = 1'b0, i_axi_wvalid = 1'b0, i_axi_bready = 1'b0;
   logic i_axi_arvalid = 1'b0, i_axi_rready = 1'b0;
   logic [17:0] i_axi_awaddr = 18'h0, i_axi_araddr = 18'h0;
   logic [31:0] i_axi_wdata = 32'h0, o_axi_rdata;
   logic [3:0] i_axi_wstrb = 4'hF;
   logic [1:0] o_axi_bresp, o_axi_rresp;
   logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
   logic o_scl_out, o_scl_oe_n, o_sda_out, o_sda_oe_n, peer_oe_n;
   logic [7:0] peer_byte, d;
   logic [1:0] r;
   int bad_count = 0, samples_checked = 0, cycles = 0;
   wire logic i_scl_in = o_scl_oe_n;
   wire logic i_sda_in = o_sda_oe_n & peer_oe_n;
   always #5 i_ref_clk = ~i_ref_clk;
   iic_data_ack_unit iic_data_ack_unit_inst (.i_ref_clk, .i_rst, .i_axi_awvalid, .o_axi_awready,
      .i_axi_awaddr, .i_axi_wvalid, .o_axi_wready, .i_axi_wdata, .i_axi_wstrb, .o_axi_bvalid,
      .i_axi_bready, .o_axi_bresp, .i_axi_arvalid, .o_axi_arready, .i_axi_araddr, .o_axi_rvalid,
      .i_axi_rready, .o_axi_rdata, .o_axi_rresp, .i_scl_in, .o_scl_out, .o_scl_oe_n, .i_sda_in,
      .o_sda_out, .o_sda_oe_n);
   iic_peer_model iic_peer_model_inst (.i_rst, .i_scl(i_scl_in), .i_sda(i_sda_in),
      .i_ack_en(ack_en), .o_sda_oe_n(peer_oe_n), .o_byte(peer_byte));
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] v, input logic [1:0] er);
      @(posedge i_ref_clk);
      i_axi_awaddr <= {idx, 2'b00};
      i_axi_wdata <= {24'h0, v};
      i_axi_awvalid <= 1'b1;
      i_axi_wvalid <= 1'b1;
      i_axi_bready <= 1'b1;
      do
      begin
         @(posedge i_ref_clk);
         if (o_axi_awready) i_axi_awvalid <= 1'b0;
         if (o_axi_wready) i_axi_wvalid <= 1'b0;
      end
      while (i_axi_awvalid || i_axi_wvalid);
      while (!o_axi_bvalid) @(posedge i_ref_clk);
      check({6'h0, o_axi_bresp}, {6'h0, er});
      i_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] idx);
      @(posedge i_ref_clk);
      i_axi_araddr <= {idx, 2'b00};
      i_axi_arvalid <= 1'b1;
      i_axi_rready <= 1'b1;
      do @(posedge i_ref_clk); while (!o_axi_arready);
      i_axi_arvalid <= 1'b0;
      do @(posedge i_ref_clk); while (!o_axi_rvalid);
      d = o_axi_rdata[7:0];
      r = o_axi_rresp;
      i_axi_rready <= 1'b0;
   endtask
   task automatic rdc(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er);
      rd(idx);
      check(d, e);
      check({6'h0, r}, {6'h0, er});
   endtask
   // polls the flag; the cycle ceiling ends a frame that never finishes
   task automatic wait_irq;
      d = 8'h00;
      while (d[CTL_IRQ_BIT] !== 1'b1) rd(IDX_CONTROL);
   endtask
   task automatic frame(input logic [7:0] v);
      wr(IDX_DATA, v, RESP_OKAY);
      wait_irq();
   endtask
   task automatic clear_irq;
      wr(IDX_CONTROL, 8'hB0, RESP_OKAY);
      rd(IDX_CONTROL);
      check({7'h0, d[CTL_IRQ_BIT]}, 8'h00);
   endtask
   always @(posedge i_ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         print_verdict();
      end
   end
   initial
   begin
      repeat (5) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      rdc(IDX_STATUS, 8'h80, RESP_OKAY);
      rdc(IDX_MODE, MODE_RESET, RESP_OKAY);
      rdc(IDX_TSC, TSC_RESERVED, RESP_OKAY);
      rdc(16'hFFC0, 8'h00, RESP_SLVERR);
      wr(IDX_STATUS, 8'h01, RESP_OKAY);
      rdc(IDX_STATUS, 8'h81, RESP_OKAY);
      $display("test registers done");
      ack_en <= 1'b1;
      wr(IDX_CONTROL, 8'hB0, RESP_OKAY);
      frame(8'hA5);
      check(peer_byte, 8'hA5);
      rdc(IDX_STATUS, 8'h80, RESP_OKAY);
      rdc(IDX_MODE, 8'h08, RESP_OKAY);
      clear_irq();
      $display("test msb frame done");
      ack_en <= 1'b0;
      wr(IDX_MODE, 8'h88, RESP_OKAY);
      frame(8'h01);
      check(peer_byte, 8'h80);
      rdc(IDX_STATUS, 8'h81, RESP_OKAY);
      clear_irq();
      $display("test lsb frame done");
      ack_en <= 1'b1;
      wr(IDX_MODE, 8'h48, RESP_OKAY);
      frame(8'h3C);
      check(peer_byte, 8'h3C);
      check({7'h0, o_scl_oe_n}, 8'h00);
      rdc(IDX_STATUS, 8'h81, RESP_OKAY);
      clear_irq();
      wait_irq();
      rdc(IDX_STATUS, 8'h80, RESP_OKAY);
      clear_irq();
      $display("test wait frame done");
      ack_en <= 1'b0;
      wr(IDX_MODE, 8'h08, RESP_OKAY);
      wr(IDX_STATUS, 8'h00, RESP_OKAY);
      wr(IDX_CONTROL, 8'hA0, RESP_OKAY);
      wait_irq();
      wr(IDX_CONTROL, 8'h20, RESP_OKAY);
      rdc(IDX_STATUS, 8'hC0, RESP_OKAY);
      rdc(IDX_DATA, 8'hFF, RESP_OKAY);
      rdc(IDX_STATUS, 8'h80, RESP_OKAY);
      $display("test receive frame done");
      wr(IDX_TSC, 8'h01, RESP_OKAY);
      rdc(IDX_TSC, 8'hFD, RESP_OKAY);
      wr(IDX_MODE, 8'h0F, RESP_OKAY);
      wr(IDX_CONTROL, 8'hB0, RESP_OKAY);
      frame(8'h80);
      check(peer_byte, 8'h81);
      rdc(IDX_MODE, 8'h08, RESP_OKAY);
      $display("test short frame done");
      print_verdict();
   end
endmodule // tb_iic_data_ack_unit
bind iic_data_ack_unit iic_data_ack_sva iic_data_ack_sva_inst (.i_ref_clk, .i_rst,
   .i_axi_awvalid, .o_axi_awready, .i_axi_wvalid, .o_axi_wready, .o_axi_bvalid, .i_axi_bready,
   .o_axi_bresp, .i_axi_arvalid, .o_axi_arready, .o_axi_rvalid, .i_axi_rready, .o_axi_rdata,
   .i_scl_in, .o_scl_out, .o_scl_oe_n, .o_sda_out, .o_sda_oe_n);

// ---- hw/iic_data_ack_unit.sv ----
// Purpose: data path, acknowledge handling and mode register of a two-wire bus unit
// Assumes: start/stop conditions are produced elsewhere; SCL low at frame start
// Notes:   open-drain pins: oe_n low pulls the line low, out is always 0
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module iic_data_ack_unit
(
   input  wire  logic                        i_ref_clk,
   input  wire  logic                        i_rst,
   input  wire  logic                        i_axi_awvalid,
   output logic                              o_axi_awready,
   input  wire  logic [iic_pkg::ADDR_W-1:0]  i_axi_awaddr,
   input  wire  logic                        i_axi_wvalid,
   output logic                              o_axi_wready,
   input  wire  logic [iic_pkg::DATA_W-1:0]  i_axi_wdata,
   input  wire  logic [3:0]                  i_axi_wstrb,
   output logic                              o_axi_bvalid,
   input  wire  logic                        i_axi_bready,
   output logic [1:0]                        o_axi_bresp,
   input  wire  logic                        i_axi_arvalid,
   output logic                              o_axi_arready,
   input  wire  logic [iic_pkg::ADDR_W-1:0]  i_axi_araddr,
   output logic                              o_axi_rvalid,
   input  wire  logic                        i_axi_rready,
   output logic [iic_pkg::DATA_W-1:0]        o_axi_rdata,
   output logic [1:0]                        o_axi_rresp,
   input  wire  logic                        i_scl_in,
   output logic                              o_scl_out,
   output logic                              o_scl_oe_n,
   input  wire  logic                        i_sda_in,
   output logic                              o_sda_out,
   output logic                              o_sda_oe_n
);
   import iic_pkg::*;

   function automatic iic_sel_e reg_sel(input logic [ADDR_W-1:0] addr);
      iic_sel_e s;
      s = SEL_NONE;
      if (addr[1:0] == 2'h0)
      begin
         case (addr[ADDR_W-1:2])
            IDX_CONTROL: s = SEL_CTL;
            IDX_STATUS:  s = SEL_STS;
            IDX_DATA:    s = SEL_DATA;
            IDX_MODE:    s = SEL_MODE;
            IDX_TSC:     s = SEL_TSC;
            default:     s = SEL_NONE;
         endcase
      end
      return s;
   endfunction

   // data bits per frame; the ack bit is counted in the code but sent separately
   function automatic logic [3:0] data_bits(input logic [2:0] bc, input logic i2c);
      logic [3:0] total;
      total = (bc == BC_NINE) ? BITS_NINE :
              (bc == BC_EIGHT) ? BITS_EIGHT : ({1'b0, bc} + BITS_ONE);
      if (i2c)
         return total - BITS_ONE;
      return (total > BITS_EIGHT) ? BITS_EIGHT : total;
   endfunction

   function automatic logic out_bit(input logic [7:0] v, input logic lsb_first);
      return lsb_first ? v[0] : v[7];
   endfunction

   // axi side
   logic                 aw_held;
   logic [ADDR_W-1:0]    awaddr_q;
   logic                 w_held;
   logic [7:0]           wdata_q;
   logic                 wstrb_q;
   logic                 do_write;
   logic                 wr_en;
   logic                 rd_en;
   iic_sel_e             wr_sel;
   iic_sel_e             rd_sel;
   // registers
   logic                 ctl_en;
   logic                 ctl_master;
   logic                 ctl_transmit;
   logic                 ctl_sync_fmt;
   logic                 irq_flag;
   logic                 irq_seen;
   logic                 mode_lsb_first;
   logic                 mode_wait;
   logic [2:0]           mode_cks;
   logic [2:0]           bit_count;
   logic                 rate_ext;
   logic                 ack_value;
   logic                 ack_rx;
   logic [7:0]           tx_buffer;
   logic [7:0]           rx_buffer;
   logic [7:0]           shift_reg;
   logic                 tx_buffer_empty;
   logic                 rx_buffer_full;
   logic                 rx_pending;
   // engine
   iic_state_e           state;
   logic [3:0]           bits_left;
   logic [7:0]           half_cnt;
   logic [1:0]           scl_sync;
   logic [1:0]           sda_sync;
   logic                 scl_prev;
   logic                 scl_oe_n;
   logic                 sda_oe_n;
   logic                 i2c_fmt;
   logic                 wait_active;
   logic                 run_clk;
   logic                 tick;
   logic                 rise_ev;
   logic                 fall_ev;
   logic                 start_ev;
   logic                 last_fall;
   logic                 wait_enter;
   logic                 done_ev;
   logic                 rd_data;
   logic                 irq_clear;
   logic [7:0]           half_period;

   assign do_write = aw_held && w_held && !o_axi_bvalid;
   assign wr_sel   = reg_sel(awaddr_q);
   assign rd_sel   = reg_sel(i_axi_araddr);
   assign wr_en    = do_write && wstrb_q;
   assign rd_en    = i_axi_arvalid && o_axi_arready;
   assign rd_data  = rd_en && (rd_sel == SEL_DATA);
   assign irq_clear = wr_en && (wr_sel == SEL_CTL) && !wdata_q[CTL_IRQ_BIT] && irq_seen;

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         aw_held       <= 1'b0;
         awaddr_q      <= '0;
         o_axi_awready <= 1'b0;
      end
      else if (i_axi_awvalid && o_axi_awready)
      begin
         aw_held       <= 1'b1;
         awaddr_q      <= i_axi_awaddr;
         o_axi_awready <= 1'b0;
      end
      else if (do_write)
         aw_held <= 1'b0;
      else if (!aw_held)
         o_axi_awready <= 1'b1;
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         w_held       <= 1'b0;
         wdata_q      <= '0;
         wstrb_q      <= 1'b0;
         o_axi_wready <= 1'b0;
      end
      else if (i_axi_wvalid && o_axi_wready)
      begin
         w_held       <= 1'b1;
         wdata_q      <= i_axi_wdata[7:0];
         wstrb_q      <= i_axi_wstrb[0];
         o_axi_wready <= 1'b0;
      end
      else if (do_write)
         w_held <= 1'b0;
      else if (!w_held)
         o_axi_wready <= 1'b1;
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_axi_bvalid <= 1'b0;
         o_axi_bresp  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         o_axi_bvalid <= 1'b1;
         o_axi_bresp  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (i_axi_bready)
         o_axi_bvalid <= 1'b0;
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_axi_arready <= 1'b0;
         o_axi_rvalid  <= 1'b0;
         o_axi_rdata   <= '0;
         o_axi_rresp   <= RESP_OKAY;
      end
      else if (rd_en)
      begin
         o_axi_arready <= 1'b0;
         o_axi_rvalid  <= 1'b1;
         o_axi_rresp   <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         o_axi_rdata   <= '0;
         case (rd_sel)
            SEL_CTL:  o_axi_rdata[7:0] <= {ctl_en, 1'b0, ctl_master, ctl_transmit,
                                           1'b0, ctl_sync_fmt, irq_flag, 1'b0};
            SEL_STS:  o_axi_rdata[7:0] <= {tx_buffer_empty, rx_buffer_full, 5'h00,
                                           ctl_transmit ? ack_rx : ack_value};
            SEL_DATA: o_axi_rdata[7:0] <= rx_buffer;
            SEL_MODE: o_axi_rdata[7:0] <= {mode_lsb_first, mode_wait, mode_cks, bit_count};
            SEL_TSC:  o_axi_rdata[7:0] <= TSC_RESERVED | {7'h00, rate_ext};
            default:  o_axi_rdata[7:0] <= 8'h00;
         endcase
      end
      else if (o_axi_rvalid && i_axi_rready)
         o_axi_rvalid <= 1'b0;
      else if (!o_axi_rvalid)
         o_axi_arready <= 1'b1;
   end

   // control, mode and rate registers
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ctl_en         <= 1'b0;
         ctl_master     <= 1'b0;
         ctl_transmit   <= 1'b0;
         ctl_sync_fmt   <= 1'b0;
         mode_lsb_first <= MODE_RESET[MODE_ORD_BIT];
         mode_wait      <= MODE_RESET[MODE_WAIT_BIT];
         mode_cks       <= MODE_RESET[MODE_CKS_HI:MODE_CKS_LO];
         rate_ext       <= 1'b0;
         ack_value      <= 1'b0;
      end
      else if (wr_en)
      begin
         case (wr_sel)
            SEL_CTL:
            begin
               ctl_en       <= wdata_q[CTL_EN_BIT];
               ctl_master   <= wdata_q[CTL_MST_BIT];
               ctl_transmit <= wdata_q[CTL_TRS_BIT];
               ctl_sync_fmt <= wdata_q[CTL_SYNC_BIT];
            end
            SEL_STS:  ack_value <= wdata_q[STS_ACK_BIT];
            SEL_MODE:
            begin
               mode_lsb_first <= wdata_q[MODE_ORD_BIT];
               mode_wait      <= wdata_q[MODE_WAIT_BIT];
               mode_cks       <= wdata_q[MODE_CKS_HI:MODE_CKS_LO];
            end
            SEL_TSC:  rate_ext <= wdata_q[TSC_EXT_BIT];
            default:  ack_value <= ack_value;
         endcase
      end
   end

   // counter is software-written and reloads BC_NINE at each frame end; the reload beats a same-cycle write
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         bit_count <= BC_NINE;
      else if (done_ev)
         bit_count <= BC_NINE;
      else if (wr_en && (wr_sel == SEL_MODE))
         bit_count <= wdata_q[MODE_BC_HI:MODE_BC_LO];
   end

   // read-then-write-zero clear; a same-cycle set wins
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         irq_flag <= 1'b0;
         irq_seen <= 1'b0;
      end
      else
      begin
         if (wait_enter || done_ev)
            irq_flag <= 1'b1;
         else if (irq_clear)
            irq_flag <= 1'b0;
         if (irq_clear || wait_enter || done_ev)
            irq_seen <= 1'b0;
         else if (rd_en && (rd_sel == SEL_CTL) && irq_flag)
            irq_seen <= 1'b1;
      end
   end

   // transmit buffer; a write in the load cycle keeps the flag low
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         tx_buffer       <= 8'h00;
         tx_buffer_empty <= 1'b1;
      end
      else if (wr_en && (wr_sel == SEL_DATA))
      begin
         tx_buffer       <= wdata_q;
         tx_buffer_empty <= 1'b0;
      end
      else if (start_ev && ctl_transmit)
         tx_buffer_empty <= 1'b1;
   end

   // receive buffer; an unread byte keeps the new one parked in the shifter
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rx_buffer      <= 8'h00;
         rx_buffer_full <= 1'b0;
         rx_pending     <= 1'b0;
      end
      else if (done_ev && !ctl_transmit)
      begin
         if (!rx_buffer_full || rd_data)
         begin
            rx_buffer      <= shift_reg;
            rx_buffer_full <= 1'b1;
         end
         else
            rx_pending <= 1'b1;
      end
      else if (rd_data && rx_pending)
      begin
         rx_buffer  <= shift_reg;
         rx_pending <= 1'b0;
      end
      else if (rd_data)
         rx_buffer_full <= 1'b0;
   end

   // pin synchronisers
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         scl_sync <= 2'b11;
         sda_sync <= 2'b11;
         scl_prev <= 1'b1;
      end
      else
      begin
         scl_sync <= {scl_sync[0], i_scl_in};
         sda_sync <= {sda_sync[0], i_sda_in};
         scl_prev <= scl_sync[1];
      end
   end

   assign i2c_fmt     = !ctl_sync_fmt;
   assign wait_active = mode_wait && ctl_master && i2c_fmt;
   assign half_period = (!rate_ext && (mode_cks == CKS_FAST)) ? HALF_FAST : HALF_OTHER;
   assign run_clk     = ctl_master && ((state == ST_DATA) || (state == ST_ACK));
   assign tick        = run_clk && (half_cnt == 8'h00);
   assign rise_ev     = ctl_master ? (tick && !scl_oe_n) : (scl_sync[1] && !scl_prev);
   assign fall_ev     = ctl_master ? (tick && scl_oe_n) : (!scl_sync[1] && scl_prev);
   assign start_ev    = (state == ST_IDLE) && ctl_en &&
                        (ctl_transmit ? !tx_buffer_empty : (!rx_buffer_full && !rx_pending));
   assign last_fall   = (state == ST_DATA) && fall_ev && (bits_left == 4'h0);
   assign wait_enter  = last_fall && i2c_fmt && wait_active;
   assign done_ev     = ((state == ST_ACK) && fall_ev) || (last_fall && !i2c_fmt);

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         half_cnt <= 8'h00;
      else if (!run_clk || tick)
         half_cnt <= half_period;
      else
         half_cnt <= half_cnt - 8'h01;
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         state <= ST_IDLE;
      else
      begin
         case (state)
            ST_IDLE: if (start_ev) state <= ST_DATA;
            ST_DATA:
            begin
               if (wait_enter)
                  state <= ST_WAIT;
               else if (last_fall)
                  state <= i2c_fmt ? ST_ACK : ST_IDLE;
            end
            ST_WAIT: if (!irq_flag) state <= ST_ACK;
            ST_ACK:  if (fall_ev) state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         shift_reg <= 8'h00;
         bits_left <= 4'h0;
      end
      else if (start_ev)
      begin
         if (ctl_transmit)
            shift_reg <= tx_buffer;
         bits_left <= data_bits(bit_count, i2c_fmt);
      end
      else if ((state == ST_DATA) && rise_ev)
      begin
         shift_reg <= mode_lsb_first ? {sda_sync[1], shift_reg[7:1]}
                                     : {shift_reg[6:0], sda_sync[1]};
         bits_left <= bits_left - 4'h1;
      end
   end

   // when transmitting, the ack bit reads 0 until a remote acknowledge is captured
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         ack_rx <= 1'b0;
      else if ((state == ST_ACK) && rise_ev && ctl_transmit)
         ack_rx <= sda_sync[1];
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         sda_oe_n <= 1'b1;
      else if (start_ev)
         sda_oe_n <= !(ctl_transmit && !out_bit(tx_buffer, mode_lsb_first));
      else if (done_ev)
         sda_oe_n <= 1'b1;
      else if (last_fall)
         sda_oe_n <= !(!ctl_transmit && !ack_value);
      else if ((state == ST_DATA) && fall_ev)
         sda_oe_n <= !(ctl_transmit && !out_bit(shift_reg, mode_lsb_first));
   end

   // master holds SCL low between frames and through the wait
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         scl_oe_n <= 1'b1;
      else if (!ctl_master)
         scl_oe_n <= 1'b1;
      else if (start_ev)
         scl_oe_n <= 1'b0;
      else if (tick)
         scl_oe_n <= !scl_oe_n;
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_scl_out <= 1'b0;
         o_sda_out <= 1'b0;
      end
      else
      begin
         o_scl_out <= 1'b0;
         o_sda_out <= 1'b0;
      end
   end

   assign o_scl_oe_n = scl_oe_n;
   assign o_sda_oe_n = sda_oe_n;
endmodule // iic_data_ack_unit

// ---- hw/iic_pkg.sv ----
// Purpose: constants, register map and types of the two-wire data/ack/mode unit
// Assumes: AXI4-Lite register access, 32-bit data, one 100 MHz clock
// Notes:   printed offsets are register indexes; byte address is index times four
// Overview of operation
// - as transmitter, capture the remote acknowledge level into the ack bit.
// - as receiver, drive the software-written ack value after the data bits.
// - ack bit reads captured value when transmitting, written value when receiving.
// - one 8-bit read/write data register, transmit or receive by mode.
// - data register is shift register, receive buffer and transmit buffer.
// - transmit-buffer-empty flag is 1 whenever the transmit buffer is empty.
// - receive-buffer-full flag is 1 while valid received data is held.
// - transmit mode, after a frame, copy waiting transmit buffer into shift register.
// - receive mode, after a frame, copy shift register into empty receive buffer.
// - bit 7 selects MSB-first at 0, LSB-first at 1.
// - wait insertion acts only in master mode with two-wire bus format.
// - with wait, hold SCL low after last data bit until flag cleared.
// - without wait, data and ack back to back; flag set after ack.
// - clock select bits 5..3 with rate extension pick master clock rate.
// - extension 0 and select 001 give system clock divided by 40.
// - bit counter bits 2..0 set next transfer length, plus one ack bit.
// - counter codes 000 is 9 bits, 001..110 are 2..7, 111 is 8.
// - bit counter returns to 000 when a transfer including ack finishes.
// - interrupt flag clears only on writing 0 after reading it as 1.
package iic_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int IDX_W  = 16;

   localparam logic [IDX_W-1:0] IDX_CONTROL = 16'hFFC4;
   localparam logic [IDX_W-1:0] IDX_STATUS  = 16'hFFC5;
   localparam logic [IDX_W-1:0] IDX_DATA    = 16'hFFC6;
   localparam logic [IDX_W-1:0] IDX_MODE    = 16'hFFC7;
   localparam logic [IDX_W-1:0] IDX_TSC     = 16'hFFFC;

   localparam int CTL_EN_BIT    = 7;
   localparam int CTL_MST_BIT   = 5;
   localparam int CTL_TRS_BIT   = 4;
   localparam int CTL_SYNC_BIT  = 2;
   localparam int CTL_IRQ_BIT   = 1;
   localparam int STS_TX_BUFFER_EMPTY_BIT  = 7;
   localparam int STS_RX_BUFFER_FULL_BIT  = 6;
   localparam int STS_ACK_BIT   = 0;
   localparam int MODE_ORD_BIT  = 7;
   localparam int MODE_WAIT_BIT = 6;
   localparam int MODE_CKS_HI   = 5;
   localparam int MODE_CKS_LO   = 3;
   localparam int MODE_BC_HI    = 2;
   localparam int MODE_BC_LO    = 0;
   localparam int TSC_EXT_BIT   = 0;

   localparam logic [7:0] MODE_RESET   = 8'h08;
   localparam logic [7:0] TSC_RESERVED = 8'hFC;
   localparam logic [2:0] BC_NINE      = 3'h0;
   localparam logic [2:0] BC_EIGHT     = 3'h7;
   localparam logic [3:0] BITS_NINE    = 4'h9;
   localparam logic [3:0] BITS_EIGHT   = 4'h8;
   localparam logic [3:0] BITS_ONE     = 4'h1;

   localparam int         DIV_FAST     = 40;
   localparam int         DIV_OTHER    = 80;
   localparam logic [2:0] CKS_FAST     = 3'h1;
   localparam logic [7:0] HALF_FAST    = 8'(DIV_FAST / 2 - 1);
   localparam logic [7:0] HALF_OTHER   = 8'(DIV_OTHER / 2 - 1);

   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DATA = 2'b01,
      ST_WAIT = 2'b10,
      ST_ACK  = 2'b11
   } iic_state_e;

   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_CTL  = 3'b001,
      SEL_STS  = 3'b010,
      SEL_DATA = 3'b011,
      SEL_MODE = 3'b100,
      SEL_TSC  = 3'b101
   } iic_sel_e;
endpackage
